// ---- design/dsd_decoder.sv ----
// dual data space decoder: combined and split X/Y access, traps, registers
`timescale 1ns/10ps
`default_nettype none
module dsd_decoder #(
  parameter int RAM_WORDS = 2048
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [11:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire dsd_pkg::dsd_xrd_t x_rd_i,
  input  wire dsd_pkg::dsd_yrd_t y_rd_i,
  input  wire dsd_pkg::dsd_wr_t  wr_i,
  output dsd_pkg::dsd_rsp_t      x_rsp_o,
  output dsd_pkg::dsd_rsp_t      y_rsp_o,
  output logic                   trap_o
);
  localparam int AW = $clog2(RAM_WORDS);
  localparam logic [16:0] RAM_END = 17'(dsd_pkg::RAM_BASE) + 17'(2 * RAM_WORDS);

  logic [15:0] ram_q [RAM_WORDS];
  logic [15:0] modulo_q;
  logic [15:0] xstart_q;
  logic [15:0] xend_q;
  logic [15:0] ystart_q;
  logic [15:0] yend_q;
  logic [15:0] brev_q;
  logic [15:0] ybase_q;
  logic [15:0] fault_q;
  logic [15:0] traps_q;
  logic        ack_q;
  logic [31:0] wbdat_q;
  dsd_pkg::dsd_rsp_t x_rsp_q;
  dsd_pkg::dsd_rsp_t y_rsp_q;
  logic        trap_q;

  // address classes
  function automatic logic is_regs(input logic [15:0] a);
    return a <= dsd_pkg::REG_TOP;
  endfunction : is_regs

  function automatic logic is_ram(input logic [15:0] a);
    return a >= dsd_pkg::RAM_BASE && {1'b0, a} < RAM_END;
  endfunction : is_ram

  function automatic logic [AW-1:0] ram_idx(input logic [15:0] a);
    logic [15:0] off;
    off = a - dsd_pkg::RAM_BASE;
    return off[AW:1];
  endfunction : ram_idx

  function automatic logic [9:0] regs_idx(input logic [15:0] a);
    return (a[15:10] == 6'h00) ? {a[9:1], 1'b0} : dsd_pkg::IDX_NONE;
  endfunction : regs_idx

  // near field widens to 16 bits; otherwise full range
  function automatic logic [15:0] ea(input logic near, input logic [15:0] a);
    return near ? {3'b000, a[dsd_pkg::NEAR_W-1:0]} : a;
  endfunction : ea

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] d,
                                        input logic [1:0] be);
    return {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
  endfunction : merge

  function automatic logic [15:0] regs_word(input logic [9:0] i);
    logic [15:0] r;
    r = dsd_pkg::RV_ZERO;
    unique case (i)
      dsd_pkg::IDX_MODULO: r = modulo_q;
      dsd_pkg::IDX_XSTART: r = xstart_q;
      dsd_pkg::IDX_XEND:   r = xend_q;
      dsd_pkg::IDX_YSTART: r = ystart_q;
      dsd_pkg::IDX_YEND:   r = yend_q;
      dsd_pkg::IDX_BREV:   r = brev_q;
      dsd_pkg::IDX_YBASE:  r = ybase_q;
      dsd_pkg::IDX_FAULT:  r = fault_q;
      dsd_pkg::IDX_TRAPS:  r = traps_q;
      default:             r = dsd_pkg::RV_ZERO;
    endcase
    return r;
  endfunction : regs_word

  function automatic logic [15:0] mem_word(input logic [15:0] a);
    logic [15:0] r;
    r = dsd_pkg::RV_ZERO;
    if (is_regs(a)) begin
      r = regs_word(regs_idx(a));
    end else if (is_ram(a)) begin
      r = ram_q[ram_idx(a)];
    end
    return r;
  endfunction : mem_word

  // X read path, combined space or X-minus-Y for DSP
  logic [15:0] x_ea;
  logic        x_in_y;
  logic        x_unimpl;
  logic        x_ptr_ok;
  logic        x_trap;
  logic [15:0] x_word;
  logic [15:0] x_data;

  always_comb begin
    x_ea     = ea(x_rd_i.near, x_rd_i.addr);
    x_in_y   = x_ea >= ybase_q && is_ram(x_ea);
    x_unimpl = !is_regs(x_ea) && !is_ram(x_ea);
    x_ptr_ok = !x_rd_i.dsp || x_rd_i.ptr == dsd_pkg::PTR_XA
               || x_rd_i.ptr == dsd_pkg::PTR_XB;
    x_trap   = x_rd_i.valid && (x_unimpl || !x_ptr_ok);
    x_word   = mem_word(x_ea);
    x_data   = x_word;
    if (x_trap || (x_rd_i.dsp && x_in_y)) begin
      x_data = dsd_pkg::RV_ZERO;
    end else if (x_rd_i.byte_op) begin
      x_data = {8'h00, x_ea[0] ? x_word[15:8] : x_word[7:0]};
    end
  end

  // Y read path, DSP only, isolated Y block
  logic [15:0] y_ea;
  logic        y_in_x;
  logic        y_unimpl;
  logic        y_ptr_ok;
  logic        y_trap;
  logic [15:0] y_data;

  always_comb begin
    y_ea     = y_rd_i.addr;
    y_in_x   = is_regs(y_ea) || (is_ram(y_ea) && y_ea < ybase_q);
    y_unimpl = !is_regs(y_ea) && !is_ram(y_ea);
    y_ptr_ok = y_rd_i.ptr == dsd_pkg::PTR_YA
               || y_rd_i.ptr == dsd_pkg::PTR_YB;
    y_trap   = y_rd_i.valid && (y_unimpl || !y_ptr_ok);
    y_data   = mem_word(y_ea);
    if (y_trap || y_in_x) begin
      y_data = dsd_pkg::RV_ZERO;
    end
  end

  // write path, always combined space
  logic [15:0] w_ea;
  logic        w_ptr_ok;
  logic        w_trap;
  logic        w_go;
  logic [1:0]  w_be;
  logic [15:0] w_dat;

  always_comb begin
    w_ea     = ea(wr_i.near, wr_i.addr);
    w_ptr_ok = !wr_i.wb || wr_i.ptr == dsd_pkg::PTR_WB;
    w_trap   = wr_i.valid && (!w_ptr_ok
               || (!is_regs(w_ea) && !is_ram(w_ea)));
    w_go     = wr_i.valid && !w_trap;
    w_be     = wr_i.byte_op ? (w_ea[0] ? 2'b10 : 2'b01) : 2'b11;
    w_dat    = wr_i.byte_op ? {2{wr_i.data[7:0]}} : wr_i.data;
  end

  // register write arbitration, core first
  logic        bus_we;
  logic        reg_we;
  logic [9:0]  reg_idx;
  logic [15:0] reg_dat;
  logic [1:0]  reg_be;

  always_comb begin
    bus_we  = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
    reg_we  = 1'b0;
    reg_idx = dsd_pkg::IDX_NONE;
    reg_dat = dsd_pkg::RV_ZERO;
    reg_be  = 2'b00;
    if (w_go && is_regs(w_ea)) begin
      reg_we  = 1'b1;
      reg_idx = regs_idx(w_ea);
      reg_dat = w_dat;
      reg_be  = w_be;
    end else if (bus_we) begin
      reg_we  = 1'b1;
      reg_idx = wb_adr_i[11:2];
      reg_dat = wb_dat_i[15:0];
      reg_be  = wb_sel_i[1:0];
    end
  end

  // mode registers; start LSB fixed 0, end LSB fixed 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      modulo_q <= dsd_pkg::RV_MODULO;
      xstart_q <= dsd_pkg::RV_START;
      xend_q   <= dsd_pkg::RV_END;
      ystart_q <= dsd_pkg::RV_START;
      yend_q   <= dsd_pkg::RV_END;
      brev_q   <= dsd_pkg::RV_BREV;
      ybase_q  <= dsd_pkg::Y_BASE_RV;
    end else if (reg_we) begin
      unique case (reg_idx)
        dsd_pkg::IDX_MODULO: modulo_q <= merge(modulo_q, reg_dat, reg_be);
        dsd_pkg::IDX_XSTART: xstart_q <= merge(xstart_q, reg_dat, reg_be) & 16'hFFFE;
        dsd_pkg::IDX_XEND:   xend_q   <= merge(xend_q, reg_dat, reg_be) | 16'h0001;
        dsd_pkg::IDX_YSTART: ystart_q <= merge(ystart_q, reg_dat, reg_be) & 16'hFFFE;
        dsd_pkg::IDX_YEND:   yend_q   <= merge(yend_q, reg_dat, reg_be) | 16'h0001;
        dsd_pkg::IDX_BREV:   brev_q   <= merge(brev_q, reg_dat, reg_be);
        dsd_pkg::IDX_YBASE:  ybase_q  <= merge(ybase_q, reg_dat, reg_be) & 16'hFFFE;
        default: ;
      endcase
    end
  end

  // data RAM, byte lanes
  always_ff @(posedge clk_i) begin
    if (w_go && is_ram(w_ea)) begin
      if (w_be[0]) begin
        ram_q[ram_idx(w_ea)][7:0] <= w_dat[7:0];
      end
      if (w_be[1]) begin
        ram_q[ram_idx(w_ea)][15:8] <= w_dat[15:8];
      end
    end
  end

  // read answers, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      x_rsp_q <= '0;
      y_rsp_q <= '0;
    end else begin
      x_rsp_q <= '{valid: x_rd_i.valid, data: x_data};
      y_rsp_q <= '{valid: y_rd_i.valid, data: y_data};
    end
  end

  // trap pulse, last fault address and count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_q  <= 1'b0;
      fault_q <= dsd_pkg::RV_ZERO;
      traps_q <= dsd_pkg::RV_ZERO;
    end else begin
      trap_q <= x_trap || y_trap || w_trap;
      if (x_trap || y_trap || w_trap) begin
        fault_q <= x_trap ? x_ea : (y_trap ? y_ea : w_ea);
        traps_q <= traps_q + 16'h0001;
      end
    end
  end

  // bus slave: ack one cycle after strobe, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      wbdat_q <= 32'h0000_0000;
    end else begin
      ack_q   <= wb_cyc_i && wb_stb_i && !ack_q;
      wbdat_q <= {16'h0000, regs_word(wb_adr_i[11:2])};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = wbdat_q;
  assign x_rsp_o  = x_rsp_q;
  assign y_rsp_o  = y_rsp_q;
  assign trap_o   = trap_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_word_write;
    wr_i.valid && !wr_i.byte_op && w_go && is_ram(w_ea);
  endsequence

  sequence s_same_read;
    x_rd_i.valid && !x_rd_i.dsp && !x_rd_i.byte_op && x_ea == $past(w_ea)
      && !(wr_i.valid && w_ea == x_ea);
  endsequence

  chk_unimpl_read: assert property (
    x_rd_i.valid && x_unimpl |=> trap_o && x_rsp_o.data == 16'h0000)
    else $error("unimplemented read did not trap with zero data");

  chk_x_into_y: assert property (
    x_rd_i.valid && x_rd_i.dsp && x_in_y |=> x_rsp_o.valid && x_rsp_o.data == 16'h0000)
    else $error("X pointer into Y did not read zero");

  chk_y_into_x: assert property (
    y_rd_i.valid && y_in_x |=> y_rsp_o.valid && y_rsp_o.data == 16'h0000)
    else $error("Y pointer into X did not read zero");

  chk_y_unimpl_trap: assert property (
    y_rd_i.valid && y_unimpl |=> trap_o)
    else $error("Y read of unimplemented memory did not trap");

  chk_write_readback: assert property (
    s_word_write ##1 s_same_read |=> x_rsp_o.data == $past(wr_i.data, 2))
    else $error("combined-space write not read back");

  chk_regs_no_trap: assert property (
    x_rd_i.valid && !x_rd_i.dsp && is_regs(x_ea) && !y_rd_i.valid && !wr_i.valid
      |=> !trap_o)
    else $error("register region read trapped");

  chk_byte_lane_low: assert property (
    x_rd_i.valid && x_rd_i.byte_op && !x_trap |=> x_rsp_o.data[15:8] == 8'h00)
    else $error("byte read not on low lane");

  chk_trap_cause: assert property (
    trap_o |-> $past(x_trap || y_trap || w_trap))
    else $error("trap pulse without a faulting access");

  chk_wb_pointer: assert property (
    wr_i.valid && wr_i.wb && wr_i.ptr != dsd_pkg::PTR_WB |=> trap_o)
    else $error("write-back with wrong pointer did not trap");

  chk_dsp_x_pointer: assert property (
    x_rd_i.valid && x_rd_i.dsp && !x_ptr_ok |=> trap_o ##1 !trap_o || $past(x_trap))
    else $error("DSP X read with wrong pointer did not trap");

  chk_bus_word: assert property (
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000 ##1 !wb_ack_o)
    else $error("bus answer wider than 16 bits or ack held");

  sequence s_y_bad_ptr;
    y_rd_i.valid && !y_ptr_ok;
  endsequence

  chk_dsp_y_pointer: assert property (
    s_y_bad_ptr |=> trap_o && y_rsp_o.valid && y_rsp_o.data == 16'h0000)
    else $error("DSP Y read with wrong pointer did not trap with zero data");

  chk_dual_answer: assert property (
    x_rd_i.valid && y_rd_i.valid |=> x_rsp_o.valid && y_rsp_o.valid)
    else $error("concurrent X and Y reads not both answered");

  chk_general_pointer: assert property (
    x_rd_i.valid && !x_rd_i.dsp && !x_unimpl && !y_rd_i.valid && !wr_i.valid
      |=> !trap_o)
    else $error("general read through a working register trapped");

  chk_write_unimpl: assert property (
    wr_i.valid && !is_regs(w_ea) && !is_ram(w_ea) |=> trap_o)
    else $error("write to unimplemented memory did not trap");

  chk_trap_pulse: assert property (
    trap_o && !(x_trap || y_trap || w_trap) |=> !trap_o)
    else $error("trap request held beyond one cycle");
endmodule : dsd_decoder
`default_nettype wire

// ---- include/dsd_pkg.sv ----
// package: memory map, register indices, reset values and carriers
`default_nettype none
package dsd_pkg;
  localparam logic [15:0] REG_TOP   = 16'h07FF;
  localparam logic [15:0] RAM_BASE  = 16'h0800;
  localparam logic [15:0] Y_BASE_RV = 16'h1000;
  localparam int          NEAR_W    = 13;
  // register indices (core byte address; bus byte address is four times)
  localparam logic [9:0] IDX_MODULO = 10'h046;
  localparam logic [9:0] IDX_XSTART = 10'h048;
  localparam logic [9:0] IDX_XEND   = 10'h04A;
  localparam logic [9:0] IDX_YSTART = 10'h04C;
  localparam logic [9:0] IDX_YEND   = 10'h04E;
  localparam logic [9:0] IDX_BREV   = 10'h050;
  localparam logic [9:0] IDX_YBASE  = 10'h060;
  localparam logic [9:0] IDX_FAULT  = 10'h062;
  localparam logic [9:0] IDX_TRAPS  = 10'h064;
  localparam logic [9:0] IDX_NONE   = 10'h3FF;
  localparam logic [15:0] RV_MODULO = 16'h0000;
  localparam logic [15:0] RV_START  = 16'h0000;
  localparam logic [15:0] RV_END    = 16'h0001;
  localparam logic [15:0] RV_BREV   = 16'h0000;
  localparam logic [15:0] RV_ZERO   = 16'h0000;
  // working register numbers with fixed roles
  localparam logic [3:0] PTR_XA = 4'h8;
  localparam logic [3:0] PTR_XB = 4'h9;
  localparam logic [3:0] PTR_YA = 4'hA;
  localparam logic [3:0] PTR_YB = 4'hB;
  localparam logic [3:0] PTR_WB = 4'hD;

  typedef struct packed {
    logic        valid;
    logic        dsp;
    logic        byte_op;
    logic        near;
    logic [3:0]  ptr;
    logic [15:0] addr;
  } dsd_xrd_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  ptr;
    logic [15:0] addr;
  } dsd_yrd_t;

  typedef struct packed {
    logic        valid;
    logic        wb;
    logic        byte_op;
    logic        near;
    logic [3:0]  ptr;
    logic [15:0] addr;
    logic [15:0] data;
  } dsd_wr_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } dsd_rsp_t;
endpackage : dsd_pkg
`default_nettype wire

// ---- bench/dsd_core_model.sv ----
// core side model: X, Y and write request ports of the data space decoder
`timescale 1ns/10ps
`default_nettype none
module dsd_core_model (
  input  wire logic              clk_i,
  input  wire dsd_pkg::dsd_rsp_t x_rsp_i,
  input  wire dsd_pkg::dsd_rsp_t y_rsp_i,
  input  wire logic              trap_i,
  output var dsd_pkg::dsd_xrd_t  x_rd_o,
  output var dsd_pkg::dsd_yrd_t  y_rd_o,
  output var dsd_pkg::dsd_wr_t   wr_o
);
  initial begin
    x_rd_o = '0;
    y_rd_o = '0;
    wr_o   = '0;
  end

  // one request cycle; idle fields scrambled so stale values never match
  task automatic step(input dsd_pkg::dsd_xrd_t x, input dsd_pkg::dsd_yrd_t y,
                      input dsd_pkg::dsd_wr_t w, output dsd_pkg::dsd_rsp_t xr,
                      output dsd_pkg::dsd_rsp_t yr, output logic tr, output logic tr2);
    @(posedge clk_i);
    x_rd_o <= x;
    y_rd_o <= y;
    wr_o   <= w;
    @(posedge clk_i);
    x_rd_o <= {1'b0, ~x[22:0]};
    y_rd_o <= {1'b0, ~y[19:0]};
    wr_o   <= {1'b0, ~w[38:0]};
    #1;
    xr = x_rsp_i;
    yr = y_rsp_i;
    tr = trap_i;
    @(posedge clk_i);
    #1;
    tr2 = trap_i;
  endtask : step

  // write, then read the same place in the very next cycle
  task automatic wr_rd(input dsd_pkg::dsd_wr_t w, input dsd_pkg::dsd_xrd_t x,
                       output dsd_pkg::dsd_rsp_t xr);
    @(posedge clk_i);
    wr_o   <= w;
    @(posedge clk_i);
    wr_o   <= {1'b0, ~w[38:0]};
    x_rd_o <= x;
    @(posedge clk_i);
    x_rd_o <= {1'b0, ~x[22:0]};
    #1;
    xr = x_rsp_i;
  endtask : wr_rd
endmodule : dsd_core_model
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench: register bus and core port scenarios
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we  = 1'b0;
  logic [11:0]       adr = '0;
  logic [31:0]       dat = '0;
  logic [31:0]       wdo;
  logic [31:0]       rd;
  logic              ack;
  logic              trap;
  logic              t1;
  logic              t2;
  int                n_mismatch = 0;
  int                n_tests = 0;
  dsd_pkg::dsd_xrd_t x_rd;
  dsd_pkg::dsd_yrd_t y_rd;
  dsd_pkg::dsd_wr_t  wr;
  dsd_pkg::dsd_rsp_t x_rsp;
  dsd_pkg::dsd_rsp_t y_rsp;
  dsd_pkg::dsd_rsp_t xs;
  dsd_pkg::dsd_rsp_t ys;
  logic [11:0]       ra [10] = '{12'h118, 12'h120, 12'h128, 12'h130, 12'h138, 12'h140,
                                 12'h180, 12'h188, 12'h190, 12'hFFC};
  logic [15:0]       rv [10] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0001,
                                 16'h0000, 16'h1000, 16'h0000, 16'h0000, 16'h0000};

  dsd_decoder #(.RAM_WORDS(64)) dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
    .wb_dat_o(wdo), .wb_ack_o(ack), .x_rd_i(x_rd), .y_rd_i(y_rd), .wr_i(wr),
    .x_rsp_o(x_rsp), .y_rsp_o(y_rsp), .trap_o(trap));

  dsd_core_model core_u (.clk_i(clk), .x_rsp_i(x_rsp), .y_rsp_i(y_rsp), .trap_i(trap),
    .x_rd_o(x_rd), .y_rd_o(y_rd), .wr_o(wr));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wbx(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {16'h0000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wbx

  task automatic go(input logic [23:0] x, input logic [20:0] y, input logic [39:0] w);
    core_u.step(x, y, w, xs, ys, t1, t2);
  endtask : go

  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    #20000;
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      wbx(1'b0, ra[i], 16'h0000);
      chk(rd, {16'h0000, rv[i]});
    end
    wbx(1'b1, 12'h128, 16'h0000);
    wbx(1'b0, 12'h128, 16'h0000);
    chk(rd, 32'h0000_0001);
    // y block from 0x0840 to end of ram at 0x0880
    wbx(1'b1, 12'h180, 16'h0841);
    wbx(1'b0, 12'h180, 16'h0000);
    chk(rd, 32'h0000_0840);
    go('0, '0, {4'b1000, 4'h1, 16'h0800, 16'h1234});
    chk(t1, 1'b0);
    go('0, '0, {4'b1100, 4'hD, 16'h0860, 16'hBEEF});
    chk(t1, 1'b0);
    go({4'b1000, 4'h5, 16'h0860}, '0, '0);
    chk({t1, xs}, {2'b01, 16'hBEEF});
    for (int p = 0; p < 16; p++) begin
      go({4'b1000, p[3:0], 16'h0800}, '0, '0);
      chk({t1, xs}, {2'b01, 16'h1234});
    end
    go({4'b1100, 4'h8, 16'h0800}, {1'b1, 4'hA, 16'h0860}, '0);
    chk(xs, {1'b1, 16'h1234});
    chk(ys, {1'b1, 16'hBEEF});
    chk(t1, 1'b0);
    go({4'b1100, 4'h9, 16'h0860}, {1'b1, 4'hB, 16'h0800}, '0);
    chk({t1, xs}, {2'b01, 16'h0000});
    chk(ys, {1'b1, 16'h0000});
    go({4'b1100, 4'hA, 16'h0800}, {1'b1, 4'h8, 16'h0860}, '0);
    chk({t1, xs}, {2'b11, 16'h0000});
    chk(ys, {1'b1, 16'h0000});
    go({4'b1100, 4'h8, 16'h0880}, '0, '0);
    chk({t1, xs}, {2'b11, 16'h0000});
    chk(t2, 1'b0);
    go('0, {1'b1, 4'hA, 16'hF000}, '0);
    chk({t1, ys}, {2'b11, 16'h0000});
    go('0, '0, {4'b1000, 4'h2, 16'h2000, 16'h5A5A});
    chk(t1, 1'b1);
    go({4'b1000, 4'h2, 16'h2000}, '0, '0);
    chk({t1, xs}, {2'b11, 16'h0000});
    go('0, '0, {4'b1000, 4'h2, 16'h0810, 16'h5555});
    go('0, '0, {4'b1100, 4'hC, 16'h0810, 16'h0000});
    chk(t1, 1'b1);
    go({4'b1000, 4'h2, 16'h0810}, '0, '0);
    chk({t1, xs}, {2'b01, 16'h5555});
    core_u.wr_rd({4'b1001, 4'h7, 16'hE810, 16'h7777}, {4'b1000, 4'h7, 16'h0810}, xs);
    chk(xs, {1'b1, 16'h7777});
    go('0, '0, {4'b1010, 4'h3, 16'h0801, 16'h00AB});
    go({4'b1000, 4'h3, 16'h0801}, '0, '0);
    chk({t1, xs}, {2'b01, 16'hAB34});
    go({4'b1010, 4'h3, 16'h0801}, '0, '0);
    chk(xs, {1'b1, 16'h00AB});
    go({4'b1010, 4'h3, 16'h0800}, '0, '0);
    chk(xs, {1'b1, 16'h0034});
    go({4'b1001, 4'h4, 16'hE800}, '0, '0);
    chk({t1, xs}, {2'b01, 16'hAB34});
    go({4'b1000, 4'h4, 16'hE800}, '0, '0);
    chk({t1, xs}, {2'b11, 16'h0000});
    go('0, '0, {4'b1000, 4'h6, 16'h0046, 16'h8001});
    go({4'b1000, 4'h6, 16'h0046}, '0, '0);
    chk({t1, xs}, {2'b01, 16'h8001});
    wbx(1'b0, 12'h118, 16'h0000);
    chk(rd, 32'h0000_8001);
    wbx(1'b0, 12'h188, 16'h0000);
    chk(rd, 32'h0000_E800);
    wbx(1'b0, 12'h190, 16'h0000);
    chk(rd, 32'h0000_0007);
    final_report();
  end
endmodule : testbench
`default_nettype wire
